// File: trace_spec_elem_gen.sv
module trace_spec_elem_gen #(
   parameter int unsigned MAX_SPEC = trace_elem_pkg::MAX_SPEC_DEFAULT,
   parameter int unsigned FIFO_DEPTH = trace_elem_pkg::FIFO_DEPTH_DEFAULT
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Pipeline reports
   input wire trace_elem_pkg::insn_rpt_t i_insn,
   input wire trace_elem_pkg::spec_rpt_t i_spec,
   input wire logic [trace_elem_pkg::EVENT_W-1:0] i_event_fire,
   input wire logic i_wait_insn_select_field,
   // Stall back to the pipeline
   output logic o_stall,
   // Element stream
   output logic o_elem_valid,
   output trace_elem_pkg::elem_t o_elem,
   input wire logic i_elem_ready
);

   localparam int unsigned SLOTS = 8;
   localparam int unsigned EW = $bits(trace_elem_pkg::elem_t);

   typedef struct packed {
      logic [trace_elem_pkg::COUNT_W-1:0] outstanding;
      logic [trace_elem_pkg::COUNT_W-1:0] cancel_acc;
      logic last_atom_taken;
      logic have_atom;
      logic trace_on;
      logic txn_open;
      logic in_txn;
      logic overflow_pend;
      logic fail_pend;
      trace_elem_pkg::elem_t [SLOTS-1:0] pend;
      logic [$clog2(SLOTS+1)-1:0] pend_n;
      logic stall;
      logic out_valid;
      trace_elem_pkg::elem_t out;
   } gen_state_t;

   gen_state_t s_q, s_d;
   trace_elem_pkg::elem_t [SLOTS-1:0] slot;
   logic [SLOTS-1:0] slot_v;
   logic [$clog2(SLOTS+1)-1:0] nslot;
   logic fifo_ready;
   logic fifo_full_drop;
   logic is_bp;
   logic atom_e;
   logic [trace_elem_pkg::COUNT_W:0] sum;

   // Emits into the FIFO one element per cycle from s_q.out
   trace_elem_fifo #(
      .WIDTH(EW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(s_q.out_valid),
      .i_in_data(s_q.out),
      .o_in_ready(fifo_ready),
      .o_out_valid(o_elem_valid),
      .o_out_data(o_elem),
      .i_out_ready(i_elem_ready)
   );

   always_comb begin
      s_d = s_q;
      slot = '0;
      slot_v = '0;
      nslot = '0;
      is_bp = 1'b0;
      atom_e = 1'b0;
      sum = '0;
      fifo_full_drop = s_q.out_valid && !fifo_ready;
      s_d.out_valid = 1'b0;
      s_d.out = s_q.out;
      if (s_q.stall) begin
         // Single-element recovery cycle; pipeline is held meanwhile
         if (s_q.overflow_pend) begin
            s_d.out = '{kind: trace_elem_pkg::ELEM_OVERFLOW, payload: trace_elem_pkg::PAY_ZERO};
            s_d.out_valid = 1'b1;
            s_d.overflow_pend = 1'b0;
         end else if (s_q.fail_pend) begin
            s_d.out = '{kind: trace_elem_pkg::ELEM_TXN_FAIL, payload: trace_elem_pkg::PAY_ZERO};
            s_d.out_valid = 1'b1;
            s_d.fail_pend = 1'b0;
            s_d.txn_open = 1'b0;
         end else if (s_q.pend_n != '0) begin
            // Rest of a multi-element cycle, kept in build order
            s_d.out = s_q.pend[0];
            s_d.out_valid = 1'b1;
            for (int i = 0; i < SLOTS - 1; i++) begin
               s_d.pend[i] = s_q.pend[i + 1];
            end
            s_d.pend[SLOTS-1] = '0;
            s_d.pend_n = s_q.pend_n - 1'b1;
         end else if (s_q.in_txn && !s_q.txn_open && s_q.trace_on) begin
            s_d.out = '{kind: trace_elem_pkg::ELEM_TXN_START, payload: trace_elem_pkg::PAY_ZERO};
            s_d.out_valid = 1'b1;
            s_d.txn_open = 1'b1;
         end
         s_d.stall = fifo_full_drop || s_d.overflow_pend || s_d.fail_pend
            || s_d.pend_n != '0 || (s_q.in_txn && !s_d.txn_open && s_q.trace_on);
      end else begin
         // Ordered build of this cycle's elements into slots
         if (!s_q.trace_on && i_spec.trace_active) begin
            slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_TRACE_ON,
               payload: trace_elem_pkg::PAY_ZERO};
            slot_v[nslot[2:0]] = 1'b1;
            nslot = nslot + 1'b1;
            if (i_spec.in_txn && !s_q.txn_open) begin
               slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_TXN_START,
                  payload: trace_elem_pkg::PAY_ZERO};
               slot_v[nslot[2:0]] = 1'b1;
               nslot = nslot + 1'b1;
               s_d.txn_open = 1'b1;
            end
         end
         if (s_q.trace_on && !i_spec.trace_active && s_q.outstanding != trace_elem_pkg::CNT_ZERO) begin
            slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_DISCARD,
               payload: trace_elem_pkg::PAY_ZERO};
            slot_v[nslot[2:0]] = 1'b1;
            nslot = nslot + 1'b1;
            s_d.outstanding = trace_elem_pkg::CNT_ZERO;
            s_d.cancel_acc = trace_elem_pkg::CNT_ZERO;
            s_d.have_atom = 1'b0;
         end
         if (i_spec.trace_active) begin
            // Merged cancel flushed before any new branch point
            is_bp = i_insn.valid && (i_insn.cls != trace_elem_pkg::INSN_OTHER)
               && !(i_insn.cls == trace_elem_pkg::INSN_WAIT && !i_wait_insn_select_field);
            sum = {1'b0, s_q.cancel_acc} + {1'b0, i_spec.cancel_cnt};
            if (i_spec.cancel_cnt != trace_elem_pkg::CNT_ZERO) begin
               s_d.outstanding = (i_spec.cancel_cnt >= s_q.outstanding)
                  ? trace_elem_pkg::CNT_ZERO
                  : s_q.outstanding - i_spec.cancel_cnt;
               s_d.have_atom = 1'b0;
               if (s_q.txn_open && s_q.outstanding <= i_spec.cancel_cnt) begin
                  s_d.txn_open = 1'b0;
               end
            end
            s_d.cancel_acc = sum[trace_elem_pkg::COUNT_W-1:0];
            if ((is_bp || i_spec.mispredict || i_spec.commit_cnt != trace_elem_pkg::CNT_ZERO)
                  && s_d.cancel_acc != trace_elem_pkg::CNT_ZERO) begin
               slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_CANCEL,
                  payload: s_d.cancel_acc};
               slot_v[nslot[2:0]] = 1'b1;
               nslot = nslot + 1'b1;
               s_d.cancel_acc = trace_elem_pkg::CNT_ZERO;
            end
            if (i_spec.commit_cnt != trace_elem_pkg::CNT_ZERO) begin
               // Count-only commit: analyzer retires oldest first
               slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_COMMIT,
                  payload: i_spec.commit_cnt};
               slot_v[nslot[2:0]] = 1'b1;
               nslot = nslot + 1'b1;
               s_d.outstanding = (i_spec.commit_cnt >= s_d.outstanding)
                  ? trace_elem_pkg::CNT_ZERO : s_d.outstanding - i_spec.commit_cnt;
            end
            if (i_spec.mispredict && s_d.have_atom) begin
               slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_MISPREDICT,
                  payload: trace_elem_pkg::PAY_ZERO};
               slot_v[nslot[2:0]] = 1'b1;
               nslot = nslot + 1'b1;
               s_d.last_atom_taken = !s_q.last_atom_taken;
            end
            if (is_bp) begin
               case (i_insn.cls)
                  trace_elem_pkg::INSN_SYNC_BARRIER: atom_e = i_insn.ctx_sync;
                  trace_elem_pkg::INSN_TXN_BEGIN: atom_e = 1'b1;
                  trace_elem_pkg::INSN_WAIT: atom_e = 1'b1;
                  trace_elem_pkg::INSN_BRANCH_COND: atom_e = i_insn.taken;
                  trace_elem_pkg::INSN_CMP_BRANCH: atom_e = i_insn.taken;
                  default: atom_e = 1'b1;
               endcase
               // Barrier without context sync is not a traced branch point
               if (!(i_insn.cls == trace_elem_pkg::INSN_SYNC_BARRIER && !atom_e)) begin
                  slot[nslot[2:0]] = '{kind: atom_e ? trace_elem_pkg::ELEM_ATOM_E
                     : trace_elem_pkg::ELEM_ATOM_N, payload: trace_elem_pkg::PAY_ZERO};
                  slot_v[nslot[2:0]] = 1'b1;
                  nslot = nslot + 1'b1;
                  s_d.last_atom_taken = atom_e;
                  s_d.have_atom = 1'b1;
                  if (s_d.outstanding < trace_elem_pkg::COUNT_W'(MAX_SPEC)) begin
                     s_d.outstanding = s_d.outstanding + 1'b1;
                  end
                  if (i_insn.cls == trace_elem_pkg::INSN_TXN_BEGIN && !s_d.txn_open) begin
                     slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_TXN_START,
                        payload: trace_elem_pkg::PAY_ZERO};
                     slot_v[nslot[2:0]] = 1'b1;
                     nslot = nslot + 1'b1;
                     s_d.txn_open = 1'b1;
                  end
               end
            end
            if (s_q.txn_open && !i_spec.in_txn) begin
               slot[nslot[2:0]] = '{kind: i_spec.txn_ok_exit ? trace_elem_pkg::ELEM_TXN_COMMIT
                  : trace_elem_pkg::ELEM_TXN_FAIL, payload: trace_elem_pkg::PAY_ZERO};
               slot_v[nslot[2:0]] = 1'b1;
               nslot = nslot + 1'b1;
               s_d.txn_open = 1'b0;
            end else if (s_q.txn_open && i_spec.txn_fail) begin
               slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_TXN_FAIL,
                  payload: trace_elem_pkg::PAY_ZERO};
               slot_v[nslot[2:0]] = 1'b1;
               nslot = nslot + 1'b1;
               s_d.txn_open = 1'b0;
            end
            // Lowest event number first keeps simultaneous fires in order
            for (int e = 0; e < trace_elem_pkg::EVENT_W; e++) begin
               if (i_event_fire[e]) begin
                  slot[nslot[2:0]] = '{kind: trace_elem_pkg::ELEM_EVENT,
                     payload: trace_elem_pkg::PAYLOAD_W'(e)};
                  slot_v[nslot[2:0]] = 1'b1;
                  nslot = nslot + 1'b1;
               end
            end
         end else begin
            s_d.txn_open = 1'b0;
         end
         s_d.trace_on = i_spec.trace_active;
         s_d.in_txn = i_spec.in_txn;
         // Extra elements wait in order; the pipeline stalls while they drain
         for (int i = 0; i < SLOTS - 1; i++) begin
            s_d.pend[i] = slot[i + 1];
         end
         s_d.pend[SLOTS-1] = '0;
         if (nslot != '0) begin
            s_d.out = slot[0];
            s_d.out_valid = 1'b1;
            s_d.pend_n = nslot - 1'b1;
         end
      end
      // Set after the clear so a loss in the emitting cycle is not forgotten
      if (fifo_full_drop) begin
         s_d.overflow_pend = 1'b1;
         if (s_q.txn_open && s_d.txn_open) begin
            s_d.fail_pend = 1'b1;
         end
      end
      if (!s_q.stall) begin
         s_d.stall = fifo_full_drop || s_d.overflow_pend || s_d.pend_n != '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_stall = s_q.stall;
endmodule : trace_spec_elem_gen

// File: trace_elem_pkg.sv
package trace_elem_pkg;

   localparam int unsigned COUNT_W = 8;
   localparam int unsigned EVENT_W = 2;
   localparam int unsigned EVNUM_W = 1;
   localparam int unsigned PAYLOAD_W = 8;
   localparam int unsigned MAX_SPEC_DEFAULT = 32;
   localparam int unsigned FIFO_DEPTH_DEFAULT = 16;

   // Instruction classes reported by the pipeline
   typedef enum logic [3:0] {
      INSN_OTHER,
      INSN_BRANCH_UNCOND,
      INSN_BRANCH_COND,
      INSN_CMP_BRANCH,
      INSN_SYNC_BARRIER,
      INSN_TXN_BEGIN,
      INSN_WAIT,
      INSN_INDIRECT
   } insn_class_t;

   // Element kinds on the output stream
   typedef enum logic [3:0] {
      ELEM_ATOM_E,
      ELEM_ATOM_N,
      ELEM_CANCEL,
      ELEM_COMMIT,
      ELEM_DISCARD,
      ELEM_MISPREDICT,
      ELEM_EVENT,
      ELEM_OVERFLOW,
      ELEM_TXN_START,
      ELEM_TXN_COMMIT,
      ELEM_TXN_FAIL,
      ELEM_TRACE_ON
   } elem_kind_t;

   typedef struct packed {
      elem_kind_t kind;
      logic [PAYLOAD_W-1:0] payload;
   } elem_t;

   // One retired or speculative report per cycle
   typedef struct packed {
      logic valid;
      insn_class_t cls;
      logic taken;
      logic ctx_sync;
   } insn_rpt_t;

   // Speculation resolution and state report
   typedef struct packed {
      logic [COUNT_W-1:0] commit_cnt;
      logic [COUNT_W-1:0] cancel_cnt;
      logic mispredict;
      logic trace_active;
      logic in_txn;
      logic txn_ok_exit;
      logic txn_fail;
   } spec_rpt_t;

   localparam logic [COUNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [PAYLOAD_W-1:0] PAY_ZERO = 8'h00;

endpackage : trace_elem_pkg

// File: trace_elem_fifo.sv
module trace_elem_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
      logic [WIDTH-1:0] head;
      logic nonempty;
   } fifo_state_t;

   fifo_state_t s_q, s_d;
   logic push, pop;

   always_comb begin
      s_d = s_q;
      pop = (s_q.cnt != '0) && i_out_ready;
      push = i_in_valid && (s_q.cnt != (AW+1)'(DEPTH));
      if (push) begin
         s_d.mem[s_q.wr] = i_in_data;
         s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // Head and flag registered so the drain side comes straight from flops
      s_d.nonempty = s_d.cnt != '0;
      s_d.head = s_d.mem[s_d.rd];
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_in_ready = s_q.cnt != (AW+1)'(DEPTH);
   assign o_out_valid = s_q.nonempty;
   assign o_out_data = s_q.head;
endmodule : trace_elem_fifo

// File: trace_spec_elem_sva.sv
module trace_spec_elem_sva #(
   parameter int unsigned MAX_SPEC = 32,
   parameter int unsigned FIFO_DEPTH = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire trace_elem_pkg::insn_rpt_t i_insn,
   input wire trace_elem_pkg::spec_rpt_t i_spec,
   input wire logic [trace_elem_pkg::EVENT_W-1:0] i_event_fire,
   input wire logic i_wait_insn_select_field,
   input wire logic o_stall,
   input wire logic o_elem_valid,
   input wire trace_elem_pkg::elem_t o_elem,
   input wire logic i_elem_ready
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // Reordering would start here, so a waiting element must stay put
   AST_ELEM_HOLD: assert property (
      o_elem_valid && !i_elem_ready |=> o_elem_valid && $stable(o_elem))
      else $error("element changed while waiting");
   AST_ATOM_LAT: assert property (
      i_insn.valid && i_insn.cls == trace_elem_pkg::INSN_BRANCH_COND && !o_stall
      |-> ##2 o_elem_valid) else $error("branch atom late");
   AST_MISPREDICT: assert property (
      i_spec.mispredict && !o_stall |-> ##[2:200]
      (o_elem_valid && o_elem.kind == trace_elem_pkg::ELEM_MISPREDICT))
      else $error("mispredict element missing");
   AST_EVENT: assert property (
      (|i_event_fire) && !o_stall |-> ##[2:200]
      (o_elem_valid && o_elem.kind == trace_elem_pkg::ELEM_EVENT))
      else $error("event element missing");
   AST_TXN_START: assert property (
      $rose(i_spec.in_txn) && !o_stall |-> ##[2:200]
      (o_elem_valid && o_elem.kind == trace_elem_pkg::ELEM_TXN_START))
      else $error("transaction start missing");
   AST_TRACE_ON: assert property (
      $rose(i_spec.trace_active) && !o_stall |-> ##[2:200]
      (o_elem_valid && o_elem.kind == trace_elem_pkg::ELEM_TRACE_ON))
      else $error("trace on element missing");
   AST_TXN_COMMIT: assert property (
      i_spec.txn_ok_exit && !o_stall |-> ##[2:200]
      (o_elem_valid && o_elem.kind == trace_elem_pkg::ELEM_TXN_COMMIT))
      else $error("transaction commit missing");
   AST_TXN_FAIL: assert property (
      i_spec.txn_fail && !o_stall |-> ##[2:200]
      (o_elem_valid && o_elem.kind == trace_elem_pkg::ELEM_TXN_FAIL))
      else $error("transaction failure missing");
endmodule : trace_spec_elem_sva

bind trace_spec_elem_gen trace_spec_elem_sva #(.MAX_SPEC(MAX_SPEC), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
   .i_sys_clk(i_sys_clk),
   .i_sys_rst(i_sys_rst),
   .i_insn(i_insn),
   .i_spec(i_spec),
   .i_event_fire(i_event_fire),
   .i_wait_insn_select_field(i_wait_insn_select_field),
   .o_stall(o_stall),
   .o_elem_valid(o_elem_valid),
   .o_elem(o_elem),
   .i_elem_ready(i_elem_ready)
);

// File: trace_pipe_model.sv
module trace_pipe_model (
   input wire logic i_sys_clk,
   input wire logic i_stall,
   output trace_elem_pkg::insn_rpt_t o_insn,
   output trace_elem_pkg::spec_rpt_t o_spec,
   output logic [trace_elem_pkg::EVENT_W-1:0] o_event_fire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hang_seen = 1'h0;
   initial begin
      o_insn = '0;
      o_spec = '0;
      o_event_fire = '0;
   end
   // One report, launched once the block stops stalling, or regardless after 500 stalled cycles
   task automatic issue(input trace_elem_pkg::insn_rpt_t ins,
      input trace_elem_pkg::spec_rpt_t sp, input logic [1:0] ev);
      int n;
      n = 0;
      @(negedge i_sys_clk);
      while (i_stall && n < 500) begin
         n++;
         @(negedge i_sys_clk);
      end
      if (i_stall) hang_seen = 1'h1;
      o_insn = ins;
      o_spec = sp;
      o_event_fire = ev;
      @(negedge i_sys_clk);
      // Stale instruction fields inverted so a late sample shows up
      o_insn = '{1'h0, trace_elem_pkg::insn_class_t'(~ins.cls), ~ins.taken, ~ins.ctx_sync};
      o_spec = '{8'h00, 8'h00, 1'h0, sp.trace_active, sp.in_txn, 1'h0, 1'h0};
      o_event_fire = 2'h0;
   endtask : issue
endmodule : trace_pipe_model

// File: trace_speculation_txn_elements_test.sv
module trace_speculation_txn_elements_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'h0;
   logic i_sys_rst = 1'h1;
   logic wait_sel = 1'h1;
   logic elem_ready = 1'h0;
   logic hold_ready = 1'h0;
   logic free_run = 1'h0;
   logic seen_ovf = 1'h0;
   logic act = 1'h0;
   logic txn = 1'h0;
   logic stall;
   logic elem_valid;
   trace_elem_pkg::elem_t elem;
   trace_elem_pkg::insn_rpt_t insn;
   trace_elem_pkg::spec_rpt_t spec;
   logic [trace_elem_pkg::EVENT_W-1:0] ev_fire;
   logic [12:0] exp_q[$];
   logic [12:0] e;
   int errors = 0;
   int cmp_count = 0;

   always #4 i_sys_clk = ~i_sys_clk;

   trace_pipe_model u_pipe (.i_sys_clk(i_sys_clk), .i_stall(stall), .o_insn(insn),
      .o_spec(spec), .o_event_fire(ev_fire));
   trace_spec_elem_gen #(.MAX_SPEC(32), .FIFO_DEPTH(16)) u_dut (.i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst), .i_insn(insn), .i_spec(spec), .i_event_fire(ev_fire),
      .i_wait_insn_select_field(wait_sel), .o_stall(stall), .o_elem_valid(elem_valid),
      .o_elem(elem), .i_elem_ready(elem_ready));

   // Random back-pressure keeps the buffer partly filled
   always @(negedge i_sys_clk) elem_ready <= !hold_ready && ($urandom % 4 != 0);

   task automatic fail(input string m);
      errors++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail

   task automatic summarize();
      if (u_pipe.hang_seen) errors++;
      if (errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   task automatic want(input trace_elem_pkg::elem_kind_t k, input logic c, input logic [7:0] p);
      exp_q.push_back({c, k, p});
   endtask : want

   task automatic ins(input trace_elem_pkg::insn_class_t c, input logic t);
      u_pipe.issue('{1'h1, c, t, 1'h1}, '{8'h00, 8'h00, 1'h0, act, txn, 1'h0, 1'h0}, 2'h0);
   endtask : ins

   task automatic sp(input logic [7:0] cm, input logic [7:0] cn, input logic [2:0] f,
      input logic [1:0] ev);
      u_pipe.issue('{1'h0, trace_elem_pkg::INSN_OTHER, 1'h0, 1'h0},
         '{cm, cn, f[2], act, txn, f[1], f[0]}, ev);
   endtask : sp

   task automatic wait_q();
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(negedge i_sys_clk);
      if (exp_q.size() != 0) begin
         fail("expected element missing");
         summarize();
      end
   endtask : wait_q

   always @(posedge i_sys_clk) begin
      if (!i_sys_rst && elem_valid === 1'h1 && elem_ready) begin
         if (free_run) begin
            if (elem.kind === trace_elem_pkg::ELEM_OVERFLOW) seen_ovf = 1'h1;
         end else if (exp_q.size() == 0) begin
            fail("unexpected element");
         end else begin
            e = exp_q.pop_front();
            cmp_count++;
            if (elem.kind !== e[11:8] || (e[12] && elem.payload !== e[7:0])) begin
               fail("element mismatch");
            end
         end
      end
   end

   initial begin
      repeat (100000) @(posedge i_sys_clk);
      fail("run timeout");
      summarize();
   end

   initial begin
      trace_elem_pkg::insn_class_t c;
      logic t;
      void'($urandom(32'h0D9E));
      repeat (12) @(negedge i_sys_clk);
      i_sys_rst = 1'h0;
      act = 1'h1;
      want(trace_elem_pkg::ELEM_TRACE_ON, 1'h0, 8'h00);
      sp(8'h00, 8'h00, 3'h0, 2'h0);
      for (int i = 0; i < 16; i++) begin
         c = trace_elem_pkg::insn_class_t'(i % 8);
         t = 1'($urandom % 2);
         if (c == trace_elem_pkg::INSN_TXN_BEGIN) continue;
         // Not-taken is reserved for these, so never offered
         if (c inside {trace_elem_pkg::INSN_BRANCH_UNCOND, trace_elem_pkg::INSN_INDIRECT}) t = 1'h1;
         if (c != trace_elem_pkg::INSN_OTHER) want((t || c inside {trace_elem_pkg::INSN_SYNC_BARRIER,
            trace_elem_pkg::INSN_WAIT}) ? trace_elem_pkg::ELEM_ATOM_E : trace_elem_pkg::ELEM_ATOM_N,
            1'h0, 8'h00);
         ins(c, t);
      end
      wait_sel = 1'h0;
      ins(trace_elem_pkg::INSN_WAIT, 1'h1);
      wait_sel = 1'h1;
      want(trace_elem_pkg::ELEM_COMMIT, 1'h1, 8'h04);
      sp(8'h04, 8'h00, 3'h0, 2'h0);
      sp(8'h00, 8'h01, 3'h0, 2'h0);
      sp(8'h00, 8'h02, 3'h0, 2'h0);
      want(trace_elem_pkg::ELEM_CANCEL, 1'h1, 8'h03);
      want(trace_elem_pkg::ELEM_ATOM_E, 1'h0, 8'h00);
      ins(trace_elem_pkg::INSN_BRANCH_COND, 1'h1);
      want(trace_elem_pkg::ELEM_MISPREDICT, 1'h0, 8'h00);
      sp(8'h00, 8'h00, 3'h4, 2'h0);
      for (int n = 0; n < 2; n++) begin
         want(trace_elem_pkg::ELEM_EVENT, 1'h1, 8'(n));
         sp(8'h00, 8'h00, 3'h0, 2'(1 << n));
      end
      act = 1'h0;
      want(trace_elem_pkg::ELEM_DISCARD, 1'h0, 8'h00);
      sp(8'h00, 8'h00, 3'h0, 2'h0);
      act = 1'h1;
      want(trace_elem_pkg::ELEM_TRACE_ON, 1'h0, 8'h00);
      sp(8'h00, 8'h00, 3'h0, 2'h0);
      for (int k = 0; k < 2; k++) begin
         want(trace_elem_pkg::ELEM_ATOM_E, 1'h0, 8'h00);
         txn = 1'h1;
         ins(trace_elem_pkg::INSN_TXN_BEGIN, 1'h1);
         want(trace_elem_pkg::ELEM_TXN_START, 1'h0, 8'h00);
         sp(8'h00, 8'h00, 3'h0, 2'h0);
         want(trace_elem_pkg::ELEM_ATOM_E, 1'h0, 8'h00);
         ins(trace_elem_pkg::INSN_BRANCH_UNCOND, 1'h1);
         txn = 1'h0;
         want(k == 0 ? trace_elem_pkg::ELEM_TXN_COMMIT : trace_elem_pkg::ELEM_TXN_FAIL,
            1'h0, 8'h00);
         sp(8'h00, 8'h00, k == 0 ? 3'h2 : 3'h1, 2'h0);
      end
      wait_q();
      // Flood with the sink stalled until the buffer refuses
      free_run = 1'h1;
      @(posedge i_sys_clk);
      hold_ready = 1'h1;
      // Extra edge lets the registered stall show before the next issue
      for (int i = 0; i < 24 && stall !== 1'h1; i++) begin
         ins(trace_elem_pkg::INSN_BRANCH_COND, 1'h1);
         @(negedge i_sys_clk);
      end
      @(posedge i_sys_clk);
      hold_ready = 1'h0;
      for (int i = 0; i < 300 && (elem_valid === 1'h1 || i < 20); i++) @(negedge i_sys_clk);
      cmp_count++;
      if (seen_ovf !== 1'h1) fail("no overflow element");
      summarize();
   end
endmodule : trace_speculation_txn_elements_test
